// file: wrp_defs.svh
`ifndef WRP_DEFS_SVH
`define WRP_DEFS_SVH

`define WRP_ADDR_LOWER_PTR 8'hd6
`define WRP_ADDR_UPPER_PTR 8'hd7
`define WRP_RESET_LOWER 8'hc0
`define WRP_RESET_UPPER 8'hc8
`define WRP_PAIR_STEP 8'h08
`define WRP_PAIR_NEXT 8'h01
`define WRP_WREG_PREFIX 4'hc
`define WRP_SET1_BASE 8'hc0
`define WRP_COMMON_TOP 8'hcf

`endif

// file: wrp_pkg.sv
package wrp_pkg;

   typedef enum logic [1:0] {
      WRP_PTR_NONE,
      WRP_PTR_BOTH,
      WRP_PTR_LOWER,
      WRP_PTR_UPPER
   } wrp_ptr_op_e;

   // operand request from the decoder
   typedef struct packed {
      logic valid;
      logic is_short;
      logic is_pair;
      logic use_set2;
      logic [7:0] operand;
   } wrp_opnd_s;

   // resolved register-file address
   typedef struct packed {
      logic valid;
      logic is_working;
      logic illegal;
      logic [7:0] addr_hi;
      logic [7:0] addr_lo;
   } wrp_addr_s;

endpackage

// file: wrp_pointer_addressing.sv
`timescale 1ns/1ps
`default_nettype none
`include "wrp_defs.svh"

module wrp_pointer_addressing (
   input wire logic CLK,
   input wire logic RESET,
   input wire wrp_pkg::wrp_opnd_s OPND,
   input wire wrp_pkg::wrp_ptr_op_e PTR_OP,
   input wire logic [7:0] PTR_DATA,
   input wire logic REG_WE,
   input wire logic REG_RE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output var wrp_pkg::wrp_addr_s ADDR_OUT,
   output logic [7:0] REG_RDATA,
   output logic REG_HIT,
   output logic [7:0] LOWER_PTR,
   output logic [7:0] UPPER_PTR
);
   import wrp_pkg::*;

   logic [7:0] lower_slice_pointer;
   logic [7:0] upper_slice_pointer;
   logic [7:0] next_lower;
   logic [7:0] next_upper;
   wrp_addr_s next_addr;
   logic [7:0] next_rdata;
   logic next_hit;

   // short 4-bit field to full address
   function automatic logic [7:0] wreg_addr(input logic [3:0] fld, input logic [7:0] lo,
                                            input logic [7:0] up);
      logic [7:0] ptr;
      ptr = fld[3] ? up : lo;
      return {ptr[7:3], fld[2:0]};
   endfunction

   function automatic logic is_wreg_prefix(input logic [7:0] op);
      return op[7:4] == `WRP_WREG_PREFIX;
   endfunction

   // pointers: instruction load has priority over a register write in the same cycle
   always_comb begin
      next_lower = lower_slice_pointer;
      next_upper = upper_slice_pointer;
      if (REG_WE && REG_ADDR == `WRP_ADDR_LOWER_PTR) begin
         next_lower = REG_WDATA;
      end
      if (REG_WE && REG_ADDR == `WRP_ADDR_UPPER_PTR) begin
         next_upper = REG_WDATA;
      end
      unique case (PTR_OP)
         WRP_PTR_NONE: begin
         end
         WRP_PTR_BOTH: begin
            next_lower = PTR_DATA;
            next_upper = 8'(PTR_DATA + `WRP_PAIR_STEP);
         end
         WRP_PTR_LOWER: begin
            next_lower = PTR_DATA;
         end
         WRP_PTR_UPPER: begin
            next_upper = PTR_DATA;
         end
      endcase
      if (RESET) begin
         next_lower = `WRP_RESET_LOWER;
         next_upper = `WRP_RESET_UPPER;
      end
   end

   always_ff @(posedge CLK) begin
      lower_slice_pointer <= next_lower;
      upper_slice_pointer <= next_upper;
   end

   // address resolution, one cycle latency
   always_comb begin
      logic [7:0] a;
      logic wk;
      a = 8'h00;
      wk = 1'b0;
      next_addr = '0;
      if (OPND.is_short) begin
         wk = 1'b1;
         a = wreg_addr(OPND.operand[3:0], lower_slice_pointer, upper_slice_pointer);
      end else if (is_wreg_prefix(OPND.operand)) begin
         wk = 1'b1;
         a = wreg_addr(OPND.operand[3:0], lower_slice_pointer, upper_slice_pointer);
      end else begin
         a = OPND.operand;
      end
      if (OPND.is_pair) begin
         a = {a[7:1], 1'b0};
      end
      next_addr.valid = OPND.valid;
      next_addr.is_working = OPND.valid && wk;
      // working access always lands in set 1 when above C0H, never set 2
      next_addr.illegal = OPND.valid && ((wk && OPND.use_set2 && a >= `WRP_SET1_BASE) ||
                          (!wk && OPND.use_set2) ||
                          (!wk && a >= `WRP_SET1_BASE && a <= `WRP_COMMON_TOP));
      next_addr.addr_hi = a;
      next_addr.addr_lo = {a[7:1], OPND.is_pair ? 1'b1 : a[0]};
      if (RESET) begin
         next_addr = '0;
      end
   end

   // set 1 pointer reads; no page term enters, so the common area ignores paging
   always_comb begin
      next_rdata = 8'h00;
      next_hit = 1'b0;
      if (REG_RE && REG_ADDR == `WRP_ADDR_LOWER_PTR) begin
         next_rdata = lower_slice_pointer;
         next_hit = 1'b1;
      end else if (REG_RE && REG_ADDR == `WRP_ADDR_UPPER_PTR) begin
         next_rdata = upper_slice_pointer;
         next_hit = 1'b1;
      end
      if (RESET) begin
         next_rdata = 8'h00;
         next_hit = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      ADDR_OUT <= next_addr;
      REG_RDATA <= next_rdata;
      REG_HIT <= next_hit;
      LOWER_PTR <= next_lower;
      UPPER_PTR <= next_upper;
   end

   property p_reset_ptrs;
      @(posedge CLK) RESET |=> (lower_slice_pointer == `WRP_RESET_LOWER
         && upper_slice_pointer == `WRP_RESET_UPPER);
   endproperty
   a_reset_ptrs: assert property (p_reset_ptrs) else $error("pointer reset value wrong");

   property p_dual_set;
      @(posedge CLK) disable iff (RESET) PTR_OP == WRP_PTR_BOTH
         |=> lower_slice_pointer == $past(PTR_DATA)
         && upper_slice_pointer == 8'($past(PTR_DATA) + `WRP_PAIR_STEP);
   endproperty
   a_dual_set: assert property (p_dual_set) else $error("dual set spacing wrong");

   property p_single_lower;
      @(posedge CLK) disable iff (RESET) (PTR_OP == WRP_PTR_LOWER && !REG_WE)
         |=> lower_slice_pointer == $past(PTR_DATA) && $stable(upper_slice_pointer);
   endproperty
   a_single_lower: assert property (p_single_lower) else $error("lower set wrong");

   property p_short_addr;
      @(posedge CLK) disable iff (RESET) (OPND.valid && OPND.is_short && !OPND.is_pair
         && PTR_OP == WRP_PTR_NONE && !REG_WE)
         |=> ADDR_OUT.addr_hi == {$past(OPND.operand[3] ? upper_slice_pointer[7:3]
             : lower_slice_pointer[7:3]), $past(OPND.operand[2:0])};
   endproperty
   a_short_addr: assert property (p_short_addr) else $error("short address wrong");

   property p_prefix;
      @(posedge CLK) disable iff (RESET) (OPND.valid && OPND.operand[7:4] == `WRP_WREG_PREFIX)
         |=> ADDR_OUT.is_working;
   endproperty
   a_prefix: assert property (p_prefix) else $error("prefix not working");

   property p_pair;
      @(posedge CLK) disable iff (RESET) ADDR_OUT.valid && $past(OPND.is_pair)
         |-> !ADDR_OUT.addr_hi[0]
         && ADDR_OUT.addr_lo == 8'(ADDR_OUT.addr_hi + `WRP_PAIR_NEXT);
   endproperty
   a_pair: assert property (p_pair) else $error("pair alignment wrong");

   property p_read;
      @(posedge CLK) disable iff (RESET) (REG_RE && REG_ADDR == `WRP_ADDR_UPPER_PTR)
         |=> REG_HIT && REG_RDATA == $past(upper_slice_pointer);
   endproperty
   a_read: assert property (p_read) else $error("upper pointer read wrong");

   property p_direct_common;
      @(posedge CLK) disable iff (RESET) (OPND.valid && !OPND.is_short
         && OPND.operand[7:4] == `WRP_WREG_PREFIX) |=> !ADDR_OUT.illegal || $past(OPND.use_set2);
   endproperty
   a_direct_common: assert property (p_direct_common) else $error("working ref flagged");

   // pointers move only on a pointer-set instruction or a register write
   property p_ptr_hold;
      @(posedge CLK) disable iff (RESET) (PTR_OP == WRP_PTR_NONE && !REG_WE)
         |=> $stable(lower_slice_pointer) && $stable(upper_slice_pointer);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without write");

   property p_single_upper;
      @(posedge CLK) disable iff (RESET) (PTR_OP == WRP_PTR_UPPER && !REG_WE)
         |=> upper_slice_pointer == $past(PTR_DATA) && $stable(lower_slice_pointer);
   endproperty
   a_single_upper: assert property (p_single_upper) else $error("upper set wrong");

   // decoder load and register write may collide; the instruction must win
   property p_load_wins;
      @(posedge CLK) disable iff (RESET) (PTR_OP == WRP_PTR_LOWER && REG_WE
         && REG_ADDR == `WRP_ADDR_LOWER_PTR) |=> lower_slice_pointer == $past(PTR_DATA);
   endproperty
   a_load_wins: assert property (p_load_wins) else $error("write beat pointer load");

   property p_write_lower;
      @(posedge CLK) disable iff (RESET) (PTR_OP == WRP_PTR_NONE && REG_WE
         && REG_ADDR == `WRP_ADDR_LOWER_PTR) |=> lower_slice_pointer == $past(REG_WDATA);
   endproperty
   a_write_lower: assert property (p_write_lower) else $error("lower write lost");

   property p_write_upper;
      @(posedge CLK) disable iff (RESET) (PTR_OP == WRP_PTR_NONE && REG_WE
         && REG_ADDR == `WRP_ADDR_UPPER_PTR) |=> upper_slice_pointer == $past(REG_WDATA);
   endproperty
   a_write_upper: assert property (p_write_upper) else $error("upper write lost");

   property p_read_lower;
      @(posedge CLK) disable iff (RESET) (REG_RE && REG_ADDR == `WRP_ADDR_LOWER_PTR)
         |=> REG_HIT && REG_RDATA == $past(lower_slice_pointer);
   endproperty
   a_read_lower: assert property (p_read_lower) else $error("lower pointer read wrong");

   // other set 1 registers live elsewhere, so a miss must read as zero
   property p_read_miss;
      @(posedge CLK) disable iff (RESET) !(REG_RE && (REG_ADDR == `WRP_ADDR_LOWER_PTR
         || REG_ADDR == `WRP_ADDR_UPPER_PTR)) |=> !REG_HIT && REG_RDATA == 8'h00;
   endproperty
   a_read_miss: assert property (p_read_miss) else $error("read miss not quiet");

   property p_reset_outputs;
      @(posedge CLK) RESET |=> ADDR_OUT == '0 && !REG_HIT && REG_RDATA == 8'h00
         && LOWER_PTR == `WRP_RESET_LOWER && UPPER_PTR == `WRP_RESET_UPPER;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not reset");

   property p_valid_follow;
      @(posedge CLK) disable iff (RESET) OPND.valid |=> ADDR_OUT.valid;
   endproperty
   a_valid_follow: assert property (p_valid_follow) else $error("valid operand dropped");

   property p_idle_quiet;
      @(posedge CLK) disable iff (RESET) !OPND.valid
         |=> !ADDR_OUT.valid && !ADDR_OUT.is_working && !ADDR_OUT.illegal;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("idle slot not quiet");

   property p_short_working;
      @(posedge CLK) disable iff (RESET) (OPND.valid && OPND.is_short)
         |=> ADDR_OUT.is_working;
   endproperty
   a_short_working: assert property (p_short_working) else $error("short not working");

   // only the two selected slices may ever be reached by working access
   property p_working_slice;
      @(posedge CLK) disable iff (RESET) ADDR_OUT.is_working
         |-> ADDR_OUT.addr_hi[7:3] == $past(lower_slice_pointer[7:3])
         || ADDR_OUT.addr_hi[7:3] == $past(upper_slice_pointer[7:3]);
   endproperty
   a_working_slice: assert property (p_working_slice) else $error("outside slices");

   property p_prefix_addr;
      @(posedge CLK) disable iff (RESET) (OPND.valid && !OPND.is_short && !OPND.is_pair
         && OPND.operand[7:4] == `WRP_WREG_PREFIX) |=> ADDR_OUT.addr_hi
         == {$past(OPND.operand[3] ? upper_slice_pointer[7:3] : lower_slice_pointer[7:3]),
             $past(OPND.operand[2:0])};
   endproperty
   a_prefix_addr: assert property (p_prefix_addr) else $error("prefix address wrong");

   // the flag is the only guard; the address itself cannot encode set 2
   property p_working_set2;
      @(posedge CLK) disable iff (RESET) (ADDR_OUT.is_working
         && ADDR_OUT.addr_hi >= `WRP_SET1_BASE && $past(OPND.use_set2)) |-> ADDR_OUT.illegal;
   endproperty
   a_working_set2: assert property (p_working_set2) else $error("set 2 working access");

   property p_direct_set2;
      @(posedge CLK) disable iff (RESET) (ADDR_OUT.valid && !ADDR_OUT.is_working
         && $past(OPND.use_set2)) |-> ADDR_OUT.illegal;
   endproperty
   a_direct_set2: assert property (p_direct_set2) else $error("set 2 direct access");

   property p_direct_pass;
      @(posedge CLK) disable iff (RESET) (OPND.valid && !OPND.is_short && !OPND.is_pair
         && OPND.operand[7:4] != `WRP_WREG_PREFIX) |=> ADDR_OUT.addr_hi == $past(OPND.operand)
         && !ADDR_OUT.is_working;
   endproperty
   a_direct_pass: assert property (p_direct_pass) else $error("direct address wrong");

   property p_lo_single;
      @(posedge CLK) disable iff (RESET) (OPND.valid && !OPND.is_pair)
         |=> ADDR_OUT.addr_lo == ADDR_OUT.addr_hi;
   endproperty
   a_lo_single: assert property (p_lo_single) else $error("single byte split");

endmodule
`default_nettype wire

// file: wrp_decoder_model.sv
`timescale 1ns/1ps
`default_nettype none
module wrp_decoder_model (
   input wire logic clk,
   output var wrp_pkg::wrp_opnd_s opnd,
   output var wrp_pkg::wrp_ptr_op_e ptr_op,
   output logic [7:0] ptr_data,
   output logic we,
   output logic re,
   output logic [7:0] addr,
   output logic [7:0] wdata
);
   import wrp_pkg::*;
   initial begin
      opnd = '0;
      ptr_op = WRP_PTR_NONE;
      ptr_data = 8'h00;
      we = 1'b0;
      re = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end
   // one instruction per cycle, held from falling edge to falling edge
   // write data is inverted so a lost write differs from a pointer load
   task automatic issue(input wrp_opnd_s o, input wrp_ptr_op_e p, input logic [7:0] d,
         input logic w, input logic r, input logic [7:0] a);
      @(negedge clk);
      opnd = o;
      ptr_op = p;
      ptr_data = d;
      we = w;
      re = r;
      addr = a;
      wdata = ~d;
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import wrp_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   wrp_opnd_s opnd;
   wrp_ptr_op_e ptr_op;
   wrp_addr_s addr_out;
   logic [7:0] ptr_data, reg_addr, reg_wdata, reg_rdata, lower_ptr, upper_ptr;
   logic reg_we, reg_re, reg_hit;
   int n_errors = 0;
   int check_count = 0;
   int lo, up;
   always #5 clk = ~clk;
   wrp_decoder_model i_dec (.clk(clk), .opnd(opnd), .ptr_op(ptr_op), .ptr_data(ptr_data),
      .we(reg_we), .re(reg_re), .addr(reg_addr), .wdata(reg_wdata));
   wrp_pointer_addressing i_dut (.CLK(clk), .RESET(reset), .OPND(opnd), .PTR_OP(ptr_op),
      .PTR_DATA(ptr_data), .REG_WE(reg_we), .REG_RE(reg_re), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .ADDR_OUT(addr_out), .REG_RDATA(reg_rdata), .REG_HIT(reg_hit),
      .LOWER_PTR(lower_ptr), .UPPER_PTR(upper_ptr));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(negedge clk);
      reset = 1'b1;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      lo = 'hc0;
      up = 'hc8;
      check(lower_ptr, 8'hc0);
      check(upper_ptr, 8'hc8);
      check(8'(addr_out.valid), 8'h00);
   endtask
   // expectations use the pointers as they stood before this cycle's update
   task automatic step(input wrp_opnd_s o, input wrp_ptr_op_e p, input logic [7:0] d,
         input logic w, input logic r, input logic [7:0] a);
      int sel, ad, wk, hit;
      logic ill;
      sel = o.operand[3] ? up : lo;
      wk = o.is_short || (o.operand[7:4] == 4'hc);
      ad = wk ? {sel[7:3], o.operand[2:0]} : o.operand;
      if (o.is_pair) ad = ad & 'hfe;
      ill = wk ? (o.use_set2 && ad >= 'hc0) : (o.use_set2 || (ad >= 'hc0 && ad <= 'hcf));
      hit = r && (a == 8'hd6 || a == 8'hd7);
      i_dec.issue(o, p, d, w, r, a);
      @(posedge clk);
      #1;
      check(8'(addr_out.valid), 8'(o.valid));
      if (o.valid) begin
         check(8'(addr_out.is_working), 8'(wk));
         check(8'(addr_out.illegal), 8'(ill));
         check(addr_out.addr_hi, 8'(ad));
         check(addr_out.addr_lo, 8'(o.is_pair ? ad + 1 : ad));
      end
      check(8'(reg_hit), 8'(hit));
      check(reg_rdata, hit ? 8'(a[0] ? up : lo) : 8'h00);
      if (w && a == 8'hd6) lo = 8'(~d);
      if (w && a == 8'hd7) up = 8'(~d);
      if (p == WRP_PTR_BOTH) up = (d + 8) % 256;
      if (p == WRP_PTR_BOTH || p == WRP_PTR_LOWER) lo = d;
      if (p == WRP_PTR_UPPER) up = d;
      check(lower_ptr, 8'(lo));
      check(upper_ptr, 8'(up));
   endtask
   initial begin
      wrp_opnd_s o;
      wrp_ptr_op_e p;
      logic rd;
      int r;
      r = $urandom(47);
      do_reset();
      $display("reset defaults test done");
      o = '0;
      step(o, WRP_PTR_NONE, 8'h00, 1'b0, 1'b1, 8'hd6);
      step(o, WRP_PTR_NONE, 8'h00, 1'b0, 1'b1, 8'hd7);
      step(o, WRP_PTR_NONE, 8'h00, 1'b0, 1'b1, 8'hd5);
      step(o, WRP_PTR_BOTH, 8'h70, 1'b0, 1'b0, 8'h00);
      o = {4'b1100, 8'h06};
      step(o, WRP_PTR_LOWER, 8'ha0, 1'b1, 1'b0, 8'hd6);
      step(o, WRP_PTR_UPPER, 8'h48, 1'b1, 1'b0, 8'hd6);
      $display("directed pointer test done");
      // decoder here also breaks the advised usage: set 2 references, reversed slices
      for (int i = 0; i < 400; i++) begin
         o = wrp_opnd_s'(12'($urandom));
         rd = ($urandom_range(3) == 0);
         p = rd ? WRP_PTR_NONE : wrp_ptr_op_e'($urandom_range(3));
         step(o, p, 8'($urandom), !rd && $urandom_range(1),
            rd, $urandom_range(1) ? {7'h6b, 1'($urandom)} : 8'($urandom));
      end
      $display("random traffic test done");
      do_reset();
      $display("mid-run reset test done");
      tally_and_finish();
   end
   initial begin
      #100000;
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
